//--- sdram_state_pkg.sv
// Package with command encodings, bank states and timing constants.
package sdram_state_pkg;

   // ==========================================================
   // Address field positions.
   localparam int ADDR_W = 12;
   localparam int BANK_BIT = 11;
   localparam int AUTO_PRE_BIT = 10;
   localparam int COL_W = 8;
   localparam int ROW_W = 11;

   // ==========================================================
   // Command codes on {csN, rasN, casN, weN}.
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_BST = 4'h6;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_MODE = 4'h0;

   // ==========================================================
   // Timing: row cycle time in ns and its cycle count at 200 MHz.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int ROW_CYCLE_TIME_NS = 70;
   localparam int ROW_CYCLE_CYC_INT =
      (ROW_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [4:0] ROW_CYCLE_CYC = ROW_CYCLE_CYC_INT[4:0];

   // ==========================================================
   // Per-bank state and device power state.
   typedef enum logic [2:0] {
      BANK_IDLE, BANK_ACTIVE, BANK_READ, BANK_WRITE,
      READ_AUTOPRECHARGE_STATE, WRITE_AUTOPRECHARGE_STATE
   } bank_state_t;

   typedef enum logic [2:0] {
      PWR_NORMAL, PWR_SELF_REFRESH, PWR_SR_RECOVERY,
      PWR_POWER_DOWN, PWR_SUSPEND
   } power_state_t;

endpackage : sdram_state_pkg

//--- bank_state.sv
// One bank's command-driven state register.
`timescale 1ns/10ps
module bank_state
   import sdram_state_pkg::*;
#(
   parameter logic BANK_ID = 1'b0
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic cmdValid,
   input wire logic [3:0] cmdCode,
   input wire logic [ADDR_W-1:0] addr,
   output bank_state_t bankState,
   output logic [ROW_W-1:0] openRow
);

   // ==========================================================
   // Decode.
   bank_state_t state_reg;
   bank_state_t state_next;
   logic [ROW_W-1:0] row_reg;
   wire logic isMine = (addr[BANK_BIT] == BANK_ID);
   wire logic autoPre = addr[AUTO_PRE_BIT];
   wire logic isBurst = (state_reg == BANK_READ) ||
      (state_reg == BANK_WRITE);
   wire logic canAccess = isBurst || (state_reg == BANK_ACTIVE);

   // Next state; commands illegal for the state leave it unchanged.
   always_comb begin
      state_next = state_reg;
      if (cmdValid) begin
         unique case (cmdCode)
            CMD_READ:
               if (isMine && canAccess) begin
                  state_next = autoPre ? READ_AUTOPRECHARGE_STATE
                                       : BANK_READ; // RQ10
               end
            CMD_WRITE:
               if (isMine && canAccess) begin
                  state_next = autoPre ? WRITE_AUTOPRECHARGE_STATE
                                       : BANK_WRITE; // RQ11
               end
            CMD_ACT:
               if (isMine && state_reg == BANK_IDLE) begin
                  state_next = BANK_ACTIVE; // RQ16
               end
            CMD_PRE:
               if (autoPre || isMine) begin
                  state_next = BANK_IDLE; // RQ15
               end
            CMD_BST:
               if (isBurst) begin
                  state_next = BANK_ACTIVE; // RQ17
               end
            default: state_next = state_reg;
         endcase
      end
   end

   // The bank holds its state through refresh and mode set, both idle.
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_reg <= BANK_IDLE;
         row_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (cmdValid && cmdCode == CMD_ACT && isMine &&
             state_reg == BANK_IDLE) begin
            row_reg <= addr[ROW_W-1:0]; // RQ16
         end
      end
   end

   assign bankState = state_reg;
   assign openRow = row_reg;

endmodule : bank_state

//--- sdram_cke_and_bank_command_state.sv
// Clock-enable power state machine and two-bank command tracking.
//
// Notes on behaviour
// RQ1 - A rising clock enable wakes the device from self-refresh, power-down, suspend.
// RQ2 - After self-refresh, idle follows row cycle time with only deselect or no-op.
// RQ3 - Clock enable falling in recovery with deselect or no-op enters power-down.
// RQ4 - Power-down ends on clock enable rise, holds while low, ignores inputs.
// RQ5 - Both banks idle first; clock enable low with refresh enters self-refresh.
// RQ6 - Outside idle and low-power states, clock enable falling suspends next cycle.
// RQ7 - Suspension ends the cycle after clock enable rises, holds while low.
// RQ8 - Controller waits the clock-enable setup interval before further commands.
// RQ9 - Controller presents a legal command on the cycle suspend begins.
// RQ10 - Read with bit 10 high enters auto-precharge read, else plain read.
// RQ11 - Write with bit 10 high enters auto-precharge write, else plain write.
// RQ12 - Read and write ignore column address bits 8 and 9.
// RQ13 - Controller idles both banks before refresh or mode set.
// RQ14 - Clock enable low with both banks idle enters power-down.
// RQ15 - Precharge with bit 10 high idles both banks, else the selected one.
// RQ16 - Activate opens the addressed row in an idle bank, making it active.
// RQ17 - Burst stop returns a bursting bank to row active.
`timescale 1ns/10ps
module sdram_cke_and_bank_command_state
   import sdram_state_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic clkEnable,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic [ADDR_W-1:0] addr,
   output power_state_t powerState,
   output bank_state_t bank0State,
   output bank_state_t bank1State,
   output logic [ROW_W-1:0] bank0Row,
   output logic [ROW_W-1:0] bank1Row,
   output logic [COL_W-1:0] colAddr,
   output logic colBank,
   output logic readStart,
   output logic writeStart,
   output logic modeLoad,
   output logic [ADDR_W-1:0] modeCode,
   output logic illegalCmd
);

   // ==========================================================
   // Input synchronisers: all pins pass two flops before use.
   localparam int PIN_W = 5 + ADDR_W;
   logic [PIN_W-1:0] pinMeta_reg;
   logic [PIN_W-1:0] pinSync_reg;
   logic ckePrev_reg;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
         ckePrev_reg <= 1'b0;
      end else begin
         pinMeta_reg <= {clkEnable, csN, rasN, casN, weN, addr};
         pinSync_reg <= pinMeta_reg;
         ckePrev_reg <= pinSync_reg[PIN_W-1];
      end
   end

   // ==========================================================
   // Command decode on synchronised pins.
   wire logic ckeNow = pinSync_reg[PIN_W-1];
   wire logic [3:0] cmdCode = pinSync_reg[PIN_W-2:ADDR_W];
   wire logic [ADDR_W-1:0] addrS = pinSync_reg[ADDR_W-1:0];
   wire logic ckeRise = !ckePrev_reg && ckeNow;
   wire logic ckeFall = ckePrev_reg && !ckeNow;
   wire logic isNop = cmdCode[3] || (cmdCode == CMD_NOP);
   wire logic isBstNop = cmdCode[3] || cmdCode[3:1] == 3'b011;
   wire logic bothIdle = (bank0State == BANK_IDLE) &&
      (bank1State == BANK_IDLE);

   power_state_t pwr_reg;
   power_state_t pwr_next;
   logic [4:0] rcCount_reg;
   logic [4:0] rcCount_next;
   logic illegal_reg;
   logic illegal_next;

   // Commands reach the banks only in normal state with the clock
   // running; suspend freezes banks exactly as they stood.
   wire logic cmdValid = (pwr_reg == PWR_NORMAL) && ckePrev_reg &&
      !cmdCode[3]; // RQ6

   // ==========================================================
   // Power state machine.
   always_comb begin
      pwr_next = pwr_reg;
      rcCount_next = rcCount_reg;
      illegal_next = 1'b0;
      unique case (pwr_reg)
         PWR_NORMAL: begin
            if (ckeFall && bothIdle && cmdCode == CMD_REF) begin
               pwr_next = PWR_SELF_REFRESH; // RQ5
            end else if (ckeFall && bothIdle) begin
               pwr_next = PWR_POWER_DOWN; // RQ14
            end else if (ckeFall) begin
               pwr_next = PWR_SUSPEND; // RQ6
            end
         end
         PWR_SELF_REFRESH: begin
            // Wake is taken from the synchronised level edge.
            if (ckeRise) begin
               pwr_next = PWR_SR_RECOVERY; // RQ1
               rcCount_next = ROW_CYCLE_CYC;
               illegal_next = !isNop;
            end
         end
         PWR_SR_RECOVERY: begin
            if (!isNop) begin
               illegal_next = 1'b1; // RQ2
            end
            if (ckeFall && isNop) begin
               pwr_next = PWR_POWER_DOWN; // RQ3
            end else if (rcCount_reg <= 5'h01) begin
               pwr_next = PWR_NORMAL; // RQ2
               rcCount_next = 5'h00;
            end else begin
               rcCount_next = rcCount_reg - 5'h01;
            end
         end
         PWR_POWER_DOWN: begin
            if (ckeRise) begin
               pwr_next = PWR_NORMAL; // RQ4
            end
         end
         PWR_SUSPEND: begin
            if (ckeNow) begin
               pwr_next = PWR_NORMAL; // RQ7
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pwr_reg <= PWR_NORMAL;
         rcCount_reg <= 5'h00;
         illegal_reg <= 1'b0;
      end else begin
         pwr_reg <= pwr_next;
         rcCount_reg <= rcCount_next;
         illegal_reg <= illegal_next;
      end
   end

   // ==========================================================
   // One state tracker per bank.
   bank_state_t bankSt [2];
   logic [ROW_W-1:0] bankRow [2];
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_bank
         bank_state #(
            .BANK_ID(gi[0])
         ) u_bank (
            .mclk(mclk),
            .resetn(resetn),
            .cmdValid(cmdValid),
            .cmdCode(cmdCode),
            .addr(addrS),
            .bankState(bankSt[gi]),
            .openRow(bankRow[gi])
         );
      end
   endgenerate

   assign bank0State = bankSt[0];
   assign bank1State = bankSt[1];
   assign bank0Row = bankRow[0];
   assign bank1Row = bankRow[1];

   // ==========================================================
   // Column strobe outputs; bits 8 and 9 are dropped here.
   logic [COL_W-1:0] col_reg;
   logic colBank_reg;
   logic rd_reg;
   logic wr_reg;
   logic mode_reg;
   logic [ADDR_W-1:0] modeCode_reg;
   wire logic isRd = cmdValid && cmdCode == CMD_READ;
   wire logic isWr = cmdValid && cmdCode == CMD_WRITE;
   wire logic isMode = cmdValid && cmdCode == CMD_MODE && bothIdle;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         col_reg <= '0;
         colBank_reg <= 1'b0;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         mode_reg <= 1'b0;
         modeCode_reg <= '0;
      end else begin
         rd_reg <= isRd;
         wr_reg <= isWr;
         mode_reg <= isMode;
         if (isRd || isWr) begin
            col_reg <= addrS[COL_W-1:0]; // RQ12
            colBank_reg <= addrS[BANK_BIT];
         end
         if (isMode) begin
            modeCode_reg <= addrS;
         end
      end
   end

   assign powerState = pwr_reg;
   assign colAddr = col_reg;
   assign colBank = colBank_reg;
   assign readStart = rd_reg;
   assign writeStart = wr_reg;
   assign modeLoad = mode_reg;
   assign modeCode = modeCode_reg;
   assign illegalCmd = illegal_reg;

endmodule : sdram_cke_and_bank_command_state

//--- mem_ctrl_model.sv
// Controller model that drives the command pins of the block.
`timescale 1ns/10ps
module mem_ctrl_model
   import sdram_state_pkg::*;
(
   input wire logic mclk,
   output logic clkEnable,
   output logic csN,
   output logic rasN,
   output logic casN,
   output logic weN,
   output logic [ADDR_W-1:0] addr
);
   // =========================================
   // Pins start as a no-op with clock enable high.
   initial begin
      clkEnable = 1'b1;
      {csN, rasN, casN, weN} = CMD_NOP;
      addr = 12'h000;
   end
   // One command a cycle, 1 ns after the edge; the caller picks each one, legal or not.
   task automatic send(input logic [3:0] c, input logic [11:0] a,
         input logic k);
      @(posedge mclk);
      #1;
      clkEnable = k;
      {csN, rasN, casN, weN} = c;
      addr = a;
   endtask : send
endmodule : mem_ctrl_model

//--- sdram_cmd_properties.sv
// Concurrent checks on the power and bank state ports.
`timescale 1ns/10ps
module sdram_cmd_checker
   import sdram_state_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input power_state_t powerState,
   input bank_state_t bank0State,
   input bank_state_t bank1State,
   input wire logic colBank,
   input wire logic readStart,
   input wire logic writeStart,
   input wire logic illegalCmd
);
   // =========================================
   // Recovery cycle count; it saturates so a stuck state cannot wrap.
   logic [4:0] recCnt_reg;
   logic bothIdle;
   bank_state_t selBank;
   always_ff @(posedge mclk) begin
      if (!resetn || powerState != PWR_SR_RECOVERY) recCnt_reg <= 5'h00;
      else if (recCnt_reg != 5'h1F) recCnt_reg <= recCnt_reg + 5'h01;
   end
   // Bank picked by the last column command.
   assign bothIdle = bank0State == BANK_IDLE && bank1State == BANK_IDLE;
   assign selBank = colBank ? bank1State : bank0State;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   chk_read_state: assert property (readStart |-> selBank inside
      {BANK_READ, READ_AUTOPRECHARGE_STATE}) else $error("read bad state");
   chk_write_state: assert property (writeStart |-> selBank inside
      {BANK_WRITE, WRITE_AUTOPRECHARGE_STATE}) else $error("write bad state");
   chk_pd_entry: assert property ($past(powerState) == PWR_NORMAL &&
      powerState == PWR_POWER_DOWN |-> $past(bothIdle))
      else $error("power-down with open bank");
   chk_sr_entry: assert property ($changed(powerState) &&
      powerState == PWR_SELF_REFRESH |-> $past(bothIdle))
      else $error("self-refresh with open bank");
   chk_suspend_frozen: assert property (powerState == PWR_SUSPEND &&
      $past(powerState) == PWR_SUSPEND |-> $stable(bank0State) &&
      $stable(bank1State)) else $error("bank moved in suspend");
   chk_pd_exit: assert property ($past(powerState) == PWR_POWER_DOWN &&
      powerState != PWR_POWER_DOWN |-> powerState == PWR_NORMAL)
      else $error("power-down left to wrong state");
   chk_sr_exit: assert property ($past(powerState) == PWR_SELF_REFRESH
      && powerState != PWR_SELF_REFRESH |-> powerState == PWR_SR_RECOVERY)
      else $error("self-refresh left to wrong state");
   chk_recov_len: assert property ($past(powerState) == PWR_SR_RECOVERY
      && powerState == PWR_NORMAL |-> $past(recCnt_reg) >=
      ROW_CYCLE_CYC - 5'h02) else $error("recovery too short");
   chk_illegal_src: assert property (illegalCmd |-> $past(powerState)
      inside {PWR_SELF_REFRESH, PWR_SR_RECOVERY})
      else $error("illegal flag outside wake");
   cover property (powerState == PWR_SUSPEND);
   cover property (readStart);
   cover property ($past(powerState) == PWR_SR_RECOVERY &&
      powerState == PWR_NORMAL);
endmodule : sdram_cmd_checker
bind sdram_cke_and_bank_command_state sdram_cmd_checker chk (.mclk(mclk),
   .resetn(resetn), .powerState(powerState), .bank0State(bank0State),
   .bank1State(bank1State), .colBank(colBank), .readStart(readStart),
   .writeStart(writeStart), .illegalCmd(illegalCmd));

//--- tb_top.sv
// Self-checking bench for the power and bank command state block.
`timescale 1ns/10ps
module tb_top
   import sdram_state_pkg::*;
;
   typedef struct {logic [3:0] c; logic [11:0] a; bank_state_t b0;
      bank_state_t b1; logic [1:0] rw;} vec_t;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic clkEnable, csN, rasN, casN, weN, colBank, readStart, writeStart;
   logic modeLoad, illegalCmd;
   logic [11:0] addr, modeCode;
   logic [10:0] bank0Row, bank1Row;
   logic [7:0] colAddr;
   power_state_t powerState;
   bank_state_t bank0State, bank1State;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   vec_t rows [11];
   // =========================================
   // 200 MHz clock and a cycle ceiling against hangs.
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         results();
      end
   end
   mem_ctrl_model ctrl (.mclk(mclk), .clkEnable(clkEnable), .csN(csN),
      .rasN(rasN), .casN(casN), .weN(weN), .addr(addr));
   sdram_cke_and_bank_command_state dut (.mclk(mclk), .resetn(resetn),
      .clkEnable(clkEnable), .csN(csN), .rasN(rasN), .casN(casN),
      .weN(weN), .addr(addr), .powerState(powerState),
      .bank0State(bank0State), .bank1State(bank1State),
      .bank0Row(bank0Row), .bank1Row(bank1Row), .colAddr(colAddr),
      .colBank(colBank), .readStart(readStart), .writeStart(writeStart),
      .modeLoad(modeLoad), .modeCode(modeCode), .illegalCmd(illegalCmd));
   task automatic check(input string nm, input logic [11:0] s, e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   // A command, one no-op, then two more edges to finish the three-edge answer delay.
   task automatic cmd(input logic [3:0] c, input logic [11:0] a);
      ctrl.send(c, a, 1'b1);
      ctrl.send(CMD_NOP, 12'h000, 1'b1);
      repeat (2) @(posedge mclk);
      #1;
   endtask : cmd
   task automatic waitPwr(input power_state_t p, input int lim);
      int n;
      n = 0;
      while (powerState !== p && n < lim) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("powerState", {9'h000, powerState}, {9'h000, p});
   endtask : waitPwr
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   // Table of command steps, then power and suspend cases.
   initial begin
      int n;
      logic s;
      rows = '{'{CMD_ACT, 12'h123, BANK_ACTIVE, BANK_IDLE, 2'h0},
         '{CMD_READ, 12'h305, BANK_READ, BANK_IDLE, 2'h2},
         '{CMD_BST, 12'h000, BANK_ACTIVE, BANK_IDLE, 2'h0},
         '{CMD_WRITE, 12'h300, BANK_WRITE, BANK_IDLE, 2'h1},
         '{CMD_BST, 12'h000, BANK_ACTIVE, BANK_IDLE, 2'h0},
         '{CMD_ACT, 12'h8AB, BANK_ACTIVE, BANK_ACTIVE, 2'h0},
         '{CMD_WRITE, 12'h400, WRITE_AUTOPRECHARGE_STATE, BANK_ACTIVE, 2'h1},
         '{CMD_READ, 12'hF0F, WRITE_AUTOPRECHARGE_STATE,
            READ_AUTOPRECHARGE_STATE, 2'h2},
         '{CMD_PRE, 12'h000, BANK_IDLE, READ_AUTOPRECHARGE_STATE, 2'h0},
         '{CMD_PRE, 12'h400, BANK_IDLE, BANK_IDLE, 2'h0},
         '{CMD_MODE, 12'h032, BANK_IDLE, BANK_IDLE, 2'h0}};
      repeat (8) @(posedge mclk);
      #1 resetn = 1'b1;
      waitPwr(PWR_NORMAL, 0);
      check("bank0State", {9'h000, bank0State}, 12'h000);
      $display("reset test done");
      foreach (rows[i]) begin
         cmd(rows[i].c, rows[i].a);
         check("bank0State", {9'h000, bank0State}, {9'h000, rows[i].b0});
         check("bank1State", {9'h000, bank1State}, {9'h000, rows[i].b1});
         check("starts", {10'h000, readStart, writeStart}, {10'h000, rows[i].rw});
      end
      check("colAddr", {4'h0, colAddr}, 12'h00F);
      check("colBank", {11'h000, colBank}, 12'h001);
      check("bank0Row", {1'b0, bank0Row}, 12'h123);
      check("bank1Row", {1'b0, bank1Row}, 12'h0AB);
      check("modeCode", modeCode, 12'h032);
      $display("command table test done");
      ctrl.send(CMD_NOP, 12'h000, 1'b0);
      waitPwr(PWR_POWER_DOWN, 6);
      ctrl.send(CMD_ACT, 12'h000, 1'b0);
      repeat (4) @(posedge mclk);
      waitPwr(PWR_POWER_DOWN, 0);
      ctrl.send(CMD_NOP, 12'h000, 1'b1);
      waitPwr(PWR_NORMAL, 6);
      check("bank0State", {9'h000, bank0State}, 12'h000);
      $display("power-down test done");
      ctrl.send(CMD_REF, 12'h000, 1'b0);
      ctrl.send(CMD_NOP, 12'h000, 1'b0);
      waitPwr(PWR_SELF_REFRESH, 6);
      ctrl.send(CMD_NOP, 12'h000, 1'b1);
      waitPwr(PWR_SR_RECOVERY, 6);
      n = 0;
      while (powerState === PWR_SR_RECOVERY && n < 40) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("recoveryLen", {11'h000, n >= ROW_CYCLE_CYC - 1 && n <= ROW_CYCLE_CYC + 1}, 12'h001);
      waitPwr(PWR_NORMAL, 0);
      ctrl.send(CMD_REF, 12'h000, 1'b0);
      ctrl.send(CMD_NOP, 12'h000, 1'b0);
      waitPwr(PWR_SELF_REFRESH, 6);
      ctrl.send(CMD_NOP, 12'h000, 1'b1);
      waitPwr(PWR_SR_RECOVERY, 6);
      ctrl.send(CMD_READ, 12'h000, 1'b1);
      ctrl.send(CMD_NOP, 12'h000, 1'b1);
      s = 1'b0;
      repeat (5) begin
         @(posedge mclk);
         #1;
         s |= illegalCmd;
      end
      check("illegalCmd", {11'h000, s}, 12'h001);
      ctrl.send(CMD_NOP, 12'h000, 1'b0);
      waitPwr(PWR_POWER_DOWN, 6);
      ctrl.send(CMD_NOP, 12'h000, 1'b1);
      waitPwr(PWR_NORMAL, 6);
      $display("self-refresh test done");
      cmd(CMD_ACT, 12'h010);
      ctrl.send(CMD_NOP, 12'h000, 1'b0);
      waitPwr(PWR_SUSPEND, 6);
      ctrl.send(CMD_PRE, 12'h400, 1'b0);
      repeat (4) @(posedge mclk);
      waitPwr(PWR_SUSPEND, 0);
      check("bank0State", {9'h000, bank0State}, {9'h000, BANK_ACTIVE});
      ctrl.send(CMD_NOP, 12'h000, 1'b1);
      waitPwr(PWR_NORMAL, 6);
      cmd(CMD_PRE, 12'h400);
      check("bank0State", {9'h000, bank0State}, 12'h000);
      $display("suspend test done");
      results();
   end
endmodule : tb_top
